// File: shared/async_serial_port_multidrop_defines.svh
// Register indexes, field positions and reset values of the serial port
`ifndef ASYNC_SERIAL_PORT_MULTIDROP_DEFINES_SVH
`define ASYNC_SERIAL_PORT_MULTIDROP_DEFINES_SVH

// ****************************************
// Register indexes (byte address = 4 * index)
// ****************************************
`define REG_DATA_IDX 12'hf40
`define REG_STATUS0_IDX 12'hf41
`define REG_CONTROL0_IDX 12'hf42
`define SERIAL_MULTIDROP_CONTROL_IDX 12'hf43
`define REG_STATUS1_IDX 12'hf44
`define REG_ADDR_CMP_IDX 12'hf45
`define REG_BAUD_HI_IDX 12'hf46
`define REG_BAUD_LO_IDX 12'hf47

// ****************************************
// Reset values
// ****************************************
`define CONTROL0_RST 8'h00
`define SERIAL_MULTIDROP_CONTROL_RST 8'h00
`define ADDR_CMP_RST 8'h00
`define BAUD_HI_RST 8'hff
`define BAUD_LO_RST 8'hff

// ****************************************
// Control 0 fields
// ****************************************
`define C0_TX_EN 7
`define C0_RX_EN 6
`define C0_FLOW_CONTROL_ENABLE 5
`define C0_PARITY_EN 4
`define C0_PARITY_ODD 3
`define C0_BREAK_REQUEST 2
`define C0_TWO_STOP 1
`define C0_LOOPBACK_ENABLE 0

// ****************************************
// Multidrop control fields
// ****************************************
`define C1_SCHEME_HI 7
`define C1_MULTIDROP_ENABLE 6
`define C1_SCHEME_LO 5
`define C1_NINTH_BIT_TX_VALUE 4
`define C1_DRIVER_ENABLE_POLARITY 3
`define C1_BAUD_GEN_CONTROL 2
`define C1_RX_DATA_IRQ_SELECT 1
`define C1_INFRARED_ENABLE 0

// ****************************************
// Status fields
// ****************************************
`define S0_RX_AVAIL 7
`define S0_PARITY_ERR 6
`define S0_OVERRUN 5
`define S0_FRAMING_ERR 4
`define S0_BREAK_DET 3
`define S0_TX_EMPTY 2
`define S0_TX_IDLE 1
`define S0_CTS_LEVEL 0
`define S1_RX_NINTH_BIT 0
`define S1_TIMER_EVENT 1
`define S1_ADDR_MATCHED 2

`define DATA_BITS 8
`define LAST_DATA_IDX 3'd7

`endif

// File: shared/async_serial_port_multidrop_pkg.sv
// Types shared by the serial port design
package async_serial_port_multidrop_pkg;
    typedef enum logic [2:0] {
        T_IDLE = 3'b000,
        T_START = 3'b001,
        T_DATA = 3'b011,
        T_PAR = 3'b010,
        T_STOP1 = 3'b110,
        T_STOP2 = 3'b111
    } tx_state_e;
    typedef enum logic [2:0] {
        R_IDLE = 3'b000,
        R_START = 3'b001,
        R_DATA = 3'b011,
        R_PAR = 3'b010,
        R_STOP = 3'b110
    } rx_state_e;
endpackage

// File: rtl/async_serial_port_multidrop.sv
// Serial port with multidrop mode, baud generator and APB register slave
//
// Chosen here: the APB register port.
`include "async_serial_port_multidrop_defines.svh"

module async_serial_port_multidrop
    import async_serial_port_multidrop_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [13:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Serial line
    input wire logic i_rxd,
    input wire logic i_cts_n,
    output logic o_txd,
    output logic o_driver_enable,
    // Interrupt requests
    output logic o_tx_irq,
    output logic o_rx_irq
);

    // ****************************************
    // Helpers
    // ****************************************
    // Parity bit for a byte in the chosen sense
    function automatic logic parity_of(input logic [7:0] d, input logic odd);
        parity_of = (^d) ^ odd;
    endfunction

    // ****************************************
    // Registers and APB slave
    // ****************************************
    logic [7:0] ctl0_ff;
    logic [7:0] ctl1_ff;
    logic [7:0] addr_cmp_ff;
    logic [7:0] baud_hi_ff;
    logic [7:0] baud_lo_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [7:0] nxt_rdata;
    logic hit;
    logic wr_fire;
    logic rd_fire;
    logic [11:0] idx;

    logic [7:0] tx_hold_ff;
    logic tx_full_ff;
    logic [7:0] rx_data_ff;
    logic rx_ninth_ff;
    logic rx_avail_ff;
    logic parity_err_ff;
    logic overrun_ff;
    logic framing_err_ff;
    logic break_det_ff;
    logic timer_event_ff;
    logic addr_matched_ff;
    tx_state_e tx_state_ff;
    logic tx_line_ff;
    logic cts_ff;

    assign idx = i_paddr[13:2];
    always_comb begin
        hit = 1'b1;
        nxt_rdata = 8'h00;
        case (idx)
            `REG_DATA_IDX: nxt_rdata = rx_data_ff;
            `REG_STATUS0_IDX: nxt_rdata = {rx_avail_ff, parity_err_ff, overrun_ff, framing_err_ff,
                                          break_det_ff, !tx_full_ff, tx_state_ff == T_IDLE, !i_cts_n};
            `REG_CONTROL0_IDX: nxt_rdata = ctl0_ff;
            `SERIAL_MULTIDROP_CONTROL_IDX: nxt_rdata = ctl1_ff;
            `REG_STATUS1_IDX: nxt_rdata = {5'h00, addr_matched_ff, timer_event_ff, rx_ninth_ff};
            `REG_ADDR_CMP_IDX: nxt_rdata = addr_cmp_ff;
            `REG_BAUD_HI_IDX: nxt_rdata = baud_hi_ff;
            `REG_BAUD_LO_IDX: nxt_rdata = baud_lo_ff;
            default: hit = 1'b0;
        endcase
    end

    // One wait state; answer registered
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= i_psel && i_penable && !pready_ff;
            pslverr_ff <= i_psel && i_penable && !pready_ff && !hit;
            prdata_ff <= (i_psel && i_penable && !pready_ff && !i_pwrite) ? {24'h000000, nxt_rdata} : 32'h0000_0000;
        end
    end
    assign wr_fire = i_psel && i_penable && pready_ff && i_pwrite;
    assign rd_fire = i_psel && i_penable && pready_ff && !i_pwrite;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_prdata = prdata_ff;

    // Control registers written by software
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ctl0_ff <= `CONTROL0_RST;
            ctl1_ff <= `SERIAL_MULTIDROP_CONTROL_RST;
            addr_cmp_ff <= `ADDR_CMP_RST;
            baud_hi_ff <= `BAUD_HI_RST;
            baud_lo_ff <= `BAUD_LO_RST;
        end else if (wr_fire) begin
            case (idx)
                `REG_CONTROL0_IDX: ctl0_ff <= i_pwdata[7:0];
                `SERIAL_MULTIDROP_CONTROL_IDX: ctl1_ff <= i_pwdata[7:0];
                `REG_ADDR_CMP_IDX: addr_cmp_ff <= i_pwdata[7:0];
                `REG_BAUD_HI_IDX: baud_hi_ff <= i_pwdata[7:0];
                `REG_BAUD_LO_IDX: baud_lo_ff <= i_pwdata[7:0];
                default: ;
            endcase
        end
    end

    logic tx_en, rx_en, flow_en, par_en, par_odd, brk, two_stop, loop_en;
    logic mp_en, ninth_tx, de_pol, bgc, rx_data_irq_select;
    logic [1:0] scheme;
    assign {tx_en, rx_en, flow_en, par_en, par_odd, brk, two_stop, loop_en} = ctl0_ff;
    assign scheme = {ctl1_ff[`C1_SCHEME_HI], ctl1_ff[`C1_SCHEME_LO]};
    assign mp_en = ctl1_ff[`C1_MULTIDROP_ENABLE];
    assign ninth_tx = ctl1_ff[`C1_NINTH_BIT_TX_VALUE];
    assign de_pol = ctl1_ff[`C1_DRIVER_ENABLE_POLARITY];
    assign bgc = ctl1_ff[`C1_BAUD_GEN_CONTROL];
    assign rx_data_irq_select = ctl1_ff[`C1_RX_DATA_IRQ_SELECT];

    // ****************************************
    // Baud generator
    // ****************************************
    logic [15:0] divisor;
    logic [15:0] baud_cnt_ff;
    logic tick;
    assign divisor = ({baud_hi_ff, baud_lo_ff} == 16'h0000) ? 16'h0001 : {baud_hi_ff, baud_lo_ff};
    assign tick = (baud_cnt_ff >= divisor - 16'h0001);

    // Up-counter against the divisor, so a newly written rate applies at once
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            baud_cnt_ff <= 16'h0000;
        end else begin
            baud_cnt_ff <= tick ? 16'h0000 : baud_cnt_ff + 16'h0001;
        end
    end

    // Timer use when both directions are off; write 1 clears
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            timer_event_ff <= 1'b0;
        end else if (bgc && !tx_en && !rx_en && tick) begin
            timer_event_ff <= 1'b1;
        end else if (wr_fire && idx == `REG_STATUS1_IDX && i_pwdata[`S1_TIMER_EVENT]) begin
            timer_event_ff <= 1'b0;
        end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    logic [7:0] tx_shift_ff;
    logic [2:0] tx_idx_ff;
    logic tx_go;
    logic tx_load;

    // Clear-to-send taken one clock ahead of the start decision
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cts_ff <= 1'b1;
        end else begin
            cts_ff <= i_cts_n;
        end
    end
    assign tx_go = tx_en && tx_full_ff && (!flow_en || !cts_ff) && tick;
    assign tx_load = wr_fire && idx == `REG_DATA_IDX && !tx_full_ff;

    // Holding register; writes while full are dropped
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tx_hold_ff <= 8'h00;
            tx_full_ff <= 1'b0;
        end else if (tx_load) begin
            tx_hold_ff <= i_pwdata[7:0];
            tx_full_ff <= 1'b1;
        end else if (tx_go && tx_state_ff == T_IDLE) begin
            tx_full_ff <= 1'b0;
        end
    end

    // Bit sequencer, one step per baud tick
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tx_state_ff <= T_IDLE;
            tx_line_ff <= 1'b1;
            tx_shift_ff <= 8'h00;
            tx_idx_ff <= 3'd0;
        end else if (tick) begin
            case (tx_state_ff)
                T_IDLE: begin
                    if (tx_go) begin
                        tx_shift_ff <= tx_hold_ff;
                        tx_line_ff <= 1'b0;
                        tx_state_ff <= T_START;
                    end
                end
                T_START: begin
                    tx_line_ff <= tx_shift_ff[0];
                    tx_idx_ff <= 3'd0;
                    tx_state_ff <= T_DATA;
                end
                T_DATA: begin
                    if (tx_idx_ff == `LAST_DATA_IDX) begin
                        if (mp_en) begin
                            tx_line_ff <= ninth_tx;
                            tx_state_ff <= T_PAR;
                        end else if (par_en) begin
                            tx_line_ff <= parity_of(tx_shift_ff, par_odd);
                            tx_state_ff <= T_PAR;
                        end else begin
                            tx_line_ff <= 1'b1;
                            tx_state_ff <= T_STOP1;
                        end
                    end else begin
                        tx_line_ff <= tx_shift_ff[tx_idx_ff + 3'd1];
                        tx_idx_ff <= tx_idx_ff + 3'd1;
                    end
                end
                T_PAR: begin
                    tx_line_ff <= 1'b1;
                    tx_state_ff <= T_STOP1;
                end
                T_STOP1: begin
                    tx_state_ff <= two_stop ? T_STOP2 : T_IDLE;
                end
                T_STOP2: tx_state_ff <= T_IDLE;
                default: begin
                    tx_state_ff <= T_IDLE;
                    tx_line_ff <= 1'b1;
                end
            endcase
        end
    end

    // Pin drive: break wins, loopback keeps the line idle
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_txd <= 1'b1;
            o_driver_enable <= 1'b0;
        end else begin
            o_txd <= brk ? 1'b0 : (loop_en ? 1'b1 : tx_line_ff);
            o_driver_enable <= (tx_state_ff != T_IDLE || tx_full_ff) ^ de_pol;
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    rx_state_e rx_state_ff;
    logic [15:0] rx_cnt_ff;
    logic [7:0] rx_shift_ff;
    logic [2:0] rx_idx_ff;
    logic rx_par_ff;
    logic rx_in;
    logic rx_done;
    logic is_addr;
    logic match;
    logic deliver;
    logic par_bad;
    logic rd_data;

    assign rx_in = loop_en ? tx_line_ff : i_rxd;
    assign rx_done = rx_en && rx_state_ff == R_STOP && rx_cnt_ff == 16'h0000;
    assign is_addr = mp_en && rx_par_ff;
    assign match = rx_shift_ff == addr_cmp_ff;
    assign par_bad = !mp_en && par_en && (rx_par_ff != parity_of(rx_shift_ff, par_odd));
    assign rd_data = rd_fire && idx == `REG_DATA_IDX;

    // Multidrop delivery filter
    always_comb begin
        deliver = 1'b1;
        if (mp_en) begin
            case (scheme)
                2'b00: deliver = 1'b1;
                2'b01: deliver = is_addr;
                2'b10: deliver = is_addr ? match : addr_matched_ff;
                2'b11: deliver = !is_addr && addr_matched_ff;
                default: deliver = 1'b1;
            endcase
        end
    end

    // Mid-bit sampling sequencer
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !rx_en) begin
            rx_state_ff <= R_IDLE;
            rx_cnt_ff <= 16'h0000;
            rx_shift_ff <= 8'h00;
            rx_idx_ff <= 3'd0;
            rx_par_ff <= 1'b0;
        end else begin
            rx_cnt_ff <= (rx_cnt_ff == 16'h0000) ? divisor - 16'h0001 : rx_cnt_ff - 16'h0001;
            case (rx_state_ff)
                R_IDLE: begin
                    rx_cnt_ff <= (divisor - 16'h0001) >> 1; // Half a bit to mid-start
                    if (!rx_in) begin
                        rx_state_ff <= R_START;
                    end
                end
                R_START: begin
                    if (rx_cnt_ff == 16'h0000) begin
                        rx_idx_ff <= 3'd0;
                        rx_par_ff <= 1'b0;
                        rx_state_ff <= rx_in ? R_IDLE : R_DATA;
                    end
                end
                R_DATA: begin
                    if (rx_cnt_ff == 16'h0000) begin
                        rx_shift_ff <= {rx_in, rx_shift_ff[7:1]};
                        rx_idx_ff <= rx_idx_ff + 3'd1;
                        if (rx_idx_ff == `LAST_DATA_IDX) begin
                            rx_state_ff <= (mp_en || par_en) ? R_PAR : R_STOP;
                        end
                    end
                end
                R_PAR: begin
                    if (rx_cnt_ff == 16'h0000) begin
                        rx_par_ff <= rx_in;
                        rx_state_ff <= R_STOP;
                    end
                end
                R_STOP: begin
                    if (rx_cnt_ff == 16'h0000) begin
                        rx_state_ff <= R_IDLE;
                    end
                end
                default: rx_state_ff <= R_IDLE;
            endcase
        end
    end

    // Received byte, flags; a new event wins over a clear
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rx_data_ff <= 8'h00;
            rx_ninth_ff <= 1'b0;
            rx_avail_ff <= 1'b0;
            overrun_ff <= 1'b0;
            parity_err_ff <= 1'b0;
            framing_err_ff <= 1'b0;
            break_det_ff <= 1'b0;
            addr_matched_ff <= 1'b0;
        end else begin
            if (rx_done && is_addr) begin
                addr_matched_ff <= match;
            end
            if (rx_done && deliver) begin
                rx_data_ff <= rx_shift_ff;
                rx_ninth_ff <= rx_par_ff;
                rx_avail_ff <= 1'b1;
            end else if (rd_data) begin
                rx_avail_ff <= 1'b0;
            end
            if (rx_done && deliver && rx_avail_ff) begin
                overrun_ff <= 1'b1;
            end else if (rd_data) begin
                overrun_ff <= 1'b0;
            end
            if (rx_done && deliver && par_bad) begin
                parity_err_ff <= 1'b1;
            end else if (rd_data) begin
                parity_err_ff <= 1'b0;
            end
            if (rx_done && !rx_in) begin
                framing_err_ff <= 1'b1;
            end else if (rd_data) begin
                framing_err_ff <= 1'b0;
            end
            if (rx_done && !rx_in && rx_shift_ff == 8'h00 && !rx_par_ff) begin
                break_det_ff <= 1'b1;
            end else if (rd_data) begin
                break_det_ff <= 1'b0;
            end
        end
    end

    // Separate interrupt requests per direction
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_tx_irq <= 1'b0;
            o_rx_irq <= 1'b0;
        end else begin
            o_tx_irq <= tx_en && !tx_full_ff;
            o_rx_irq <= rx_en && (rx_avail_ff || (!rx_data_irq_select && (overrun_ff || parity_err_ff
                        || framing_err_ff || break_det_ff)));
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    chk_break_forces_low: assert property (brk |=> !o_txd)
        else $error("break request did not hold the line low");
    chk_one_stop_bit: assert property (tx_state_ff == T_STOP1 && tick && !two_stop |=> tx_state_ff == T_IDLE)
        else $error("one stop bit expected");
    chk_two_stop_bits: assert property (tx_state_ff == T_STOP1 && tick && two_stop |=> tx_state_ff == T_STOP2)
        else $error("second stop bit missing");
    chk_cts_holds_start: assert property (tx_state_ff == T_IDLE && flow_en && cts_ff |=> tx_state_ff == T_IDLE)
        else $error("character started while clear-to-send deasserted");
    chk_cts_finish_char: assert property (tx_state_ff == T_DATA && flow_en && cts_ff |=> tx_state_ff != T_IDLE)
        else $error("character cut short by clear-to-send");
    chk_ninth_bit_pos: assert property (tx_state_ff == T_DATA && tx_idx_ff == 3'd7 && tick && mp_en
        |=> tx_state_ff == T_PAR && tx_line_ff == $past(ninth_tx))
        else $error("ninth bit not sent after data");
    chk_parity_sense: assert property (tx_state_ff == T_DATA && tx_idx_ff == 3'd7 && tick && !mp_en && par_en
        |=> tx_line_ff == ((^tx_shift_ff) ^ $past(par_odd)))
        else $error("wrong parity bit sent");
    chk_start_bit_low: assert property (tx_state_ff == T_IDLE && tx_go |=> tx_state_ff == T_START && !tx_line_ff)
        else $error("start bit not low");
    chk_addr_only_scheme: assert property (rx_done && mp_en && scheme == 2'b01 && !rx_par_ff && !rx_avail_ff
        |=> !rx_avail_ff)
        else $error("data byte delivered under address-only scheme");
    chk_overrun_flag: assert property (rx_done && deliver && rx_avail_ff |=> overrun_ff)
        else $error("overrun not flagged");
    chk_de_follows_tx: assert property (tx_state_ff != T_IDLE && !de_pol ##1 !de_pol |-> o_driver_enable)
        else $error("driver enable inactive while sending");

    cov_char_sent: cover property (tx_state_ff == T_STOP1 && tick);
    cov_addr_match: cover property (rx_done && is_addr && match);
    cov_loopback_rx: cover property (loop_en && rx_done && deliver);
    cov_cts_pause: cover property (tx_full_ff && flow_en && cts_ff && tick);

endmodule // async_serial_port_multidrop

// File: bench/remote_station.sv
// Behavioural remote serial station facing the serial port
module remote_station (
    // Clock and lines
    input wire logic i_clk_sys,
    input wire logic i_line,
    output logic o_line,
    // Expected frame shape
    input wire logic i_nine,
    input wire logic [1:0] i_nstop,
    // Decoded frame {stops_high, ninth, data}
    output logic o_got,
    output logic [9:0] o_frame
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DIV = 4;
    initial begin
        o_line = 1'b1;
        o_got = 1'b0;
        o_frame = '0;
    end
    // ****************************************
    // Receive: mid-bit samples, LSB first
    // ****************************************
    always begin : rx_frame
        int n;
        @(negedge i_line);
        n = i_nine ? 9 : 8;
        repeat (DIV / 2) @(negedge i_clk_sys);
        o_frame = {~i_line, 9'h0};
        for (int i = 0; i < n + i_nstop; i++) begin
            repeat (DIV) @(negedge i_clk_sys);
            if (i < n) o_frame[i] = i_line;
            else o_frame[9] = o_frame[9] & i_line;
        end
        o_got = 1'b1;
        @(negedge i_clk_sys);
        o_got = 1'b0;
    end
    // Send: low start, LSB first, high stop, idle high after
    task automatic send(input logic [8:0] v, input int nb);
        for (int i = -1; i <= nb; i++) begin
            o_line <= i < 0 ? 1'b0 : i == nb ? 1'b1 : v[i];
            repeat (DIV) @(posedge i_clk_sys);
        end
    endtask
endmodule // remote_station

// File: bench/test_async_serial_port_multidrop.sv
// Self-checking bench of the serial port against a remote station
`include "async_serial_port_multidrop_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_async_serial_port_multidrop;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_cts_n = 1'b0;
    logic [13:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata;
    logic o_pready, o_pslverr, o_txd, i_rxd, o_driver_enable, o_tx_irq, o_rx_irq, got, av, nine = 1'b1, quiet = 1'b0;
    logic [1:0] nstop = 2'd1;
    logic [9:0] frame, es;
    logic [32:0] ea;
    logic [32:0] aq[$];
    logic [9:0] sq[$];
    logic [7:0] d;
    logic [3:0] mk[4] = '{4'b0111, 4'b1101, 4'b0011, 4'b0001};
    int miscompares = 0, cmp_count = 0, cycles = 0;
    always #2.5 i_clk_sys = ~i_clk_sys;
    async_serial_port_multidrop async_serial_port_multidrop_i (.i_clk_sys, .i_sys_rst, .i_psel, .i_penable,
        .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rxd, .i_cts_n, .o_txd,
        .o_driver_enable, .o_tx_irq, .o_rx_irq);
    remote_station remote_station_i (.i_clk_sys, .i_line(o_txd), .o_line(i_rxd), .i_nine(nine),
        .i_nstop(nstop), .o_got(got), .o_frame(frame));
    // ****************************************
    // Checkers and run control
    // ****************************************
    // Read answers taken at the edge that samples ready high
    always @(posedge i_clk_sys) begin
        if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite) begin
            ea = aq.pop_front();
            `CHK("read", ea, {o_pslverr, o_prdata})
        end
    end
    // Serial frames compared as the station decodes them
    always @(posedge got) begin
        if (!quiet) begin
            es = sq.size() ? sq.pop_front() : 10'h0;
            `CHK("frame", es, frame)
        end
    end
    // Hang guard
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // APB transfer held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] v);
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= {idx, 2'b00};
        i_pwdata <= {24'h0, v};
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] idx, input logic [32:0] e);
        aq.push_back(e);
        apb(1'b0, idx, 8'h00);
    endtask
    // Sends one character, optionally held by clear-to-send first
    task automatic tx(input logic [7:0] c0, input logic [7:0] c1, input logic [9:0] e, input logic hold);
        i_cts_n <= hold;
        nine <= c0[4] | c1[6];
        nstop <= c0[1] ? 2'd2 : 2'd1;
        apb(1'b1, `SERIAL_MULTIDROP_CONTROL_IDX, c1);
        apb(1'b1, `REG_CONTROL0_IDX, c0);
        sq.push_back(e);
        apb(1'b1, `REG_DATA_IDX, e[7:0]);
        if (hold) begin
            repeat (60) @(posedge i_clk_sys);
            `CHK("held", 1, sq.size())
            `CHK("de", 1'b1, o_driver_enable)
            `CHK("txirq", 1'b0, o_tx_irq)
            i_cts_n <= 1'b0;
            repeat (20) @(posedge i_clk_sys);
            i_cts_n <= 1'b1;
        end
        while (sq.size() != 0) @(posedge i_clk_sys);
        i_cts_n <= 1'b0;
        repeat (20) @(posedge i_clk_sys);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h75efa980));
        repeat (20) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        rd(`SERIAL_MULTIDROP_CONTROL_IDX, 33'h0);
        rd(`REG_BAUD_HI_IDX, 33'h0ff);
        rd(12'hf48, 33'h100000000);
        d = $urandom;
        apb(1'b1, `SERIAL_MULTIDROP_CONTROL_IDX, d);
        rd(`SERIAL_MULTIDROP_CONTROL_IDX, {25'h0, d});
        apb(1'b1, `REG_BAUD_HI_IDX, 8'h00);
        apb(1'b1, `REG_BAUD_LO_IDX, 8'h04);
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            tx({4'h9, k[0], 1'b0, k[1], 1'b0}, 8'h00, {1'b1, ^d ^ k[0], d}, 1'b0);
        end
        for (int b = 0; b < 2; b++) tx(8'h80, {3'b010, b[0], 4'h0}, {1'b1, b[0], d}, 1'b0);
        tx(8'ha0, 8'h00, {2'b10, d}, 1'b1);
        // Break forces the line low
        quiet <= 1'b1;
        apb(1'b1, `REG_CONTROL0_IDX, 8'h84);
        repeat (3) @(posedge i_clk_sys);
        `CHK("break", 1'b0, o_txd)
        apb(1'b1, `REG_CONTROL0_IDX, 8'h80);
        repeat (80) @(posedge i_clk_sys);
        quiet <= 1'b0;
        // Loopback: line stays idle, byte comes back inside
        apb(1'b1, `REG_CONTROL0_IDX, 8'hc1);
        d = $urandom;
        apb(1'b1, `REG_DATA_IDX, d);
        repeat (20) @(posedge i_clk_sys);
        `CHK("loop_line", 1'b1, o_txd)
        repeat (40) @(posedge i_clk_sys);
        rd(`REG_DATA_IDX, {25'h0, d});
        // Received parity, good then bad
        apb(1'b1, `REG_CONTROL0_IDX, 8'h58);
        for (int e = 0; e < 2; e++) begin
            d = $urandom;
            remote_station_i.send({^d ^ 1'b1 ^ e[0], d}, 9);
            rd(`REG_STATUS0_IDX, {25'h0, 1'b1, e[0], 6'h07});
            `CHK("rxirq", 1'b1, o_rx_irq)
            rd(`REG_DATA_IDX, {25'h0, d});
        end
        // Every receive scheme against match, data, mismatch, data
        apb(1'b1, `REG_CONTROL0_IDX, 8'h40);
        apb(1'b1, `REG_ADDR_CMP_IDX, 8'h5a);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `SERIAL_MULTIDROP_CONTROL_IDX, {s[1], 1'b1, s[0], 5'h0});
            for (int j = 0; j < 4; j++) begin
                d = j[0] ? 8'h3c : 8'h5a ^ {7'h0, j[1]};
                remote_station_i.send({~j[0], d}, 9);
                av = mk[j][s];
                rd(`REG_STATUS0_IDX, {25'h0, av, 7'h07});
                `CHK("rxirq", av, o_rx_irq)
                if (av) rd(`REG_DATA_IDX, {25'h0, d});
            end
        end
        // Baud generator as a timer with both directions off
        apb(1'b1, `REG_CONTROL0_IDX, 8'h00);
        apb(1'b1, `REG_STATUS1_IDX, 8'h02);
        rd(`REG_STATUS1_IDX, 33'h000);
        apb(1'b1, `SERIAL_MULTIDROP_CONTROL_IDX, 8'h04);
        repeat (8) @(posedge i_clk_sys);
        rd(`REG_STATUS1_IDX, 33'h002);
        end_of_test();
    end
endmodule // test_async_serial_port_multidrop
